/* File: hdl/ppc_pkg.sv */
// Purpose: constants and types for the port power management and MSI capability block
// Assumes: byte addresses of one configuration dword per register
// Notes:   strap defaults and field positions live here, register reset values are set in ppc_cap_regs
//
// Overview of operation
// - PM capability id always reads 01h
// - next pointers 48h and 68h, loadable, read-only
// - PM revision field reads 011b
// - PME clock bit hardwired zero
// - D1 and D2 support bits read zero
// - PME support field defaults to 19h
// - device specific init bit defaults zero
// - power state field RW, D0..D3hot encodings
// - D3hot to D0 write gives hot reset, plus internal reset when no soft reset is clear
// - no soft reset bit set suppresses the internal reset
// - PME messages only while PME enable set
// - data select writable only when enabled externally
// - PME status always reads zero
// - MSI capability id always reads 05h
// - MSI enable set forbids legacy INTx use
// - 64-bit address capable bit reads one
// - message address dword aligned, low bits zero
// - upper address only valid with 64-bit capability
package ppc_pkg;
    // ----------------------------------------
    // offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_PM_CAP   = 8'h40;
    localparam logic [7:0] OFF_PM_CTL   = 8'h44;
    localparam logic [7:0] OFF_MSI_CAP  = 8'h48;
    localparam logic [7:0] OFF_MSI_ADDR = 8'h4c;
    // ----------------------------------------
    // fixed values and defaults
    // ----------------------------------------
    localparam logic [7:0] PM_CAP_ID    = 8'h01;
    localparam logic [7:0] MSI_CAP_ID   = 8'h05;
    localparam logic [7:0] PM_NEXT_DEF  = 8'h48;
    localparam logic [7:0] MSI_NEXT_DEF = 8'h68;
    localparam logic [2:0] PM_REV       = 3'h3;
    localparam logic [4:0] PME_SUP_DEF  = 5'h19;
    localparam logic [1:0] PS_D0        = 2'h0;
    localparam logic [1:0] PS_D3HOT     = 2'h3;
    localparam logic       MSI64_CAP    = 1'h1;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int NEXT_LSB   = 8;
    localparam int REV_LSB    = 16;
    localparam int PMECLK_BIT = 19;
    localparam int DSI_BIT    = 21;
    localparam int AUX_LSB    = 22;
    localparam int D1_BIT     = 25;
    localparam int D2_BIT     = 26;
    localparam int PMESUP_LSB = 27;
    localparam int PS_LSB     = 0;
    localparam int NOSOFT_BIT = 3;
    localparam int PMEEN_BIT  = 8;
    localparam int DSEL_LSB   = 9;
    localparam int PMEST_BIT  = 15;
    localparam int DATA_LSB   = 24;
    localparam int MSIEN_BIT  = 16;
    localparam int MME_LSB    = 20;
    localparam int MSI64_BIT  = 23;
    localparam int ADDR_LSB   = 2;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] pmNext;
        logic [7:0] msiNext;
        logic       noSoftRst;
        logic       devSpecInit;
        logic [2:0] auxCurrent;
        logic [4:0] pmeSupport;
        logic [7:0] dataByte;
    } ppc_strap_t;

    localparam ppc_strap_t STRAP_DEF = '{pmNext: PM_NEXT_DEF, msiNext: MSI_NEXT_DEF,
        noSoftRst: 1'h1, devSpecInit: 1'h0, auxCurrent: 3'h0,
        pmeSupport: PME_SUP_DEF, dataByte: 8'h00};

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } ppc_cfg_req_t;

    typedef struct packed {
        logic [1:0]  pwrState;
        logic        pmeEn;
        logic [3:0]  dataSel;
        logic        msiEn;
        logic [2:0]  msiMme;
        logic [29:0] msiAddr;
        ppc_strap_t  strap;
        logic [31:0] rdata;
        logic        ack;
        logic        hotRst;
        logic        intRst;
    } ppc_state_t;
endpackage

/* File: hdl/ppc_rst_sync.sv */
// Purpose: release of the asynchronous reset through two flops
// Assumes: rst_b active low
// Notes:   assertion is immediate, release is synchronous
`timescale 1ns/1ps
`default_nettype none
module ppc_rst_sync (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // synchronised copy
    output logic      rstSyncB
);
    logic [1:0] sync_reg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync_reg <= 2'h0;
        end else begin
            sync_reg <= {sync_reg[0], 1'h1};
        end
    end

    assign rstSyncB = sync_reg[1];
endmodule
`default_nettype wire

/* File: hdl/ppc_pm_transition.sv */
// Purpose: detect the D3hot to D0 power state write
// Assumes: wrStrobe is one cycle per accepted write
// Notes:   purely combinational, caller registers the pulses
`timescale 1ns/1ps
`default_nettype none
module ppc_pm_transition (
    // power state write
    input  wire logic       wrStrobe,
    input  wire logic [1:0] prevState,
    input  wire logic [1:0] newState,
    input  wire logic       noSoftRst,
    // results
    output logic            hotRst,
    output logic            intRst
);
    always_comb begin
        hotRst = wrStrobe && prevState == ppc_pkg::PS_D3HOT
                 && newState == ppc_pkg::PS_D0;
        intRst = hotRst && !noSoftRst;
    end
endmodule
`default_nettype wire

/* File: hdl/ppc_cap_regs.sv */
// Purpose: PM and MSI capability registers of one switch port
// Assumes: one configuration request per cycle, answered the next cycle
// Notes:   ce low freezes every flop but the reset synchroniser, requests are then not taken
`timescale 1ns/1ps
`default_nettype none
module ppc_cap_regs (
    // clock, reset, enable
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    input  wire logic                  ce,
    // configuration requests
    input  wire logic                  cfgReq,
    input  wire ppc_pkg::ppc_cfg_req_t cfgIn,
    output logic                       cfgAck,
    output logic [31:0]                cfgRdata,
    // defaults from the serial configuration source
    input  wire logic                  strapLoad,
    input  wire ppc_pkg::ppc_strap_t   strapIn,
    input  wire logic                  dataSelWrEn,
    // PME and interrupt path
    input  wire logic                  pmeEventIn,
    output logic                       pmeMsgOut,
    output logic                       msiEnable,
    output logic                       intxPermit,
    output logic [2:0]                 msiMultiEnable,
    output logic [31:0]                msiAddr,
    output logic                       msi64Capable,
    // power state and resets
    output logic [1:0]                 pwrState,
    output logic                       hotResetPulse,
    output logic                       intResetPulse,
    output logic                       downstream_reset_out_n
);
    // ----------------------------------------
    // reset release and state
    // ----------------------------------------
    logic                rstSyncB;
    ppc_pkg::ppc_state_t st_reg;
    ppc_pkg::ppc_state_t st_next;
    logic                take;
    logic                psWrite;
    logic [31:0]         oldWord;
    logic [31:0]         mergedWord;
    logic                hotRst;
    logic                intRst;

    localparam ppc_pkg::ppc_state_t ST_RST = '{pwrState: ppc_pkg::PS_D0, pmeEn: 1'h0,
        dataSel: 4'h0, msiEn: 1'h0, msiMme: 3'h0, msiAddr: 30'h0,
        strap: ppc_pkg::STRAP_DEF, rdata: 32'h0, ack: 1'h0,
        hotRst: 1'h0, intRst: 1'h0};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstSyncB);

    ppc_rst_sync u_rst (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .rstSyncB (rstSyncB)
    );

    // ----------------------------------------
    // read view of each register
    // ----------------------------------------
    function automatic logic [31:0] readWord(input logic [7:0] addr,
                                             input ppc_pkg::ppc_state_t s);
        logic [31:0] w;
        w = 32'h0;
        if (addr == ppc_pkg::OFF_PM_CAP) begin
            w[7:0] = ppc_pkg::PM_CAP_ID;
            w[ppc_pkg::NEXT_LSB +: 8] = s.strap.pmNext;
            w[ppc_pkg::REV_LSB +: 3] = ppc_pkg::PM_REV;
            w[ppc_pkg::PMECLK_BIT] = 1'h0;
            w[ppc_pkg::DSI_BIT] = s.strap.devSpecInit;
            w[ppc_pkg::AUX_LSB +: 3] = s.strap.auxCurrent;
            w[ppc_pkg::D1_BIT] = 1'h0;
            w[ppc_pkg::D2_BIT] = 1'h0;
            w[ppc_pkg::PMESUP_LSB +: 5] = s.strap.pmeSupport;
        end else if (addr == ppc_pkg::OFF_PM_CTL) begin
            w[ppc_pkg::PS_LSB +: 2] = s.pwrState;
            w[ppc_pkg::NOSOFT_BIT] = s.strap.noSoftRst;
            w[ppc_pkg::PMEEN_BIT] = s.pmeEn;
            w[ppc_pkg::DSEL_LSB +: 4] = s.dataSel;
            w[ppc_pkg::PMEST_BIT] = 1'h0;
            w[ppc_pkg::DATA_LSB +: 8] = s.strap.dataByte;
        end else if (addr == ppc_pkg::OFF_MSI_CAP) begin
            w[7:0] = ppc_pkg::MSI_CAP_ID;
            w[ppc_pkg::NEXT_LSB +: 8] = s.strap.msiNext;
            w[ppc_pkg::MSIEN_BIT] = s.msiEn;
            w[ppc_pkg::MME_LSB +: 3] = s.msiMme;
            w[ppc_pkg::MSI64_BIT] = ppc_pkg::MSI64_CAP;
        end else if (addr == ppc_pkg::OFF_MSI_ADDR) begin
            w[31:ppc_pkg::ADDR_LSB] = s.msiAddr;
        end
        return w;
    endfunction

    // byte enables pick new bytes over old ones
    function automatic logic [31:0] mergeBytes(input logic [31:0] oldW,
                                               input logic [31:0] newW,
                                               input logic [3:0]  be);
        logic [31:0] w;
        w = oldW;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                w[i*8 +: 8] = newW[i*8 +: 8];
            end
        end
        return w;
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    assign take       = ce && cfgReq;
    assign oldWord    = readWord({cfgIn.addr[7:2], 2'h0}, st_reg);
    assign mergedWord = mergeBytes(oldWord, cfgIn.wdata, cfgIn.be);
    assign psWrite    = take && cfgIn.wr && cfgIn.be[0]
                        && {cfgIn.addr[7:2], 2'h0} == ppc_pkg::OFF_PM_CTL;

    ppc_pm_transition u_trans (
        .wrStrobe  (psWrite),
        .prevState (st_reg.pwrState),
        .newState  (mergedWord[ppc_pkg::PS_LSB +: 2]),
        .noSoftRst (st_reg.strap.noSoftRst),
        .hotRst    (hotRst),
        .intRst    (intRst)
    );

    always_comb begin
        logic [7:0] a;
        a = {cfgIn.addr[7:2], 2'h0};
        st_next = st_reg;
        st_next.ack = 1'h0;
        st_next.hotRst = 1'h0;
        st_next.intRst = 1'h0;
        if (strapLoad) begin
            st_next.strap = strapIn;
        end
        if (take) begin
            st_next.ack = 1'h1;
            if (!cfgIn.wr) begin
                st_next.rdata = readWord(a, st_reg);
            end else if (a == ppc_pkg::OFF_PM_CTL) begin
                st_next.pwrState = mergedWord[ppc_pkg::PS_LSB +: 2];
                st_next.pmeEn = mergedWord[ppc_pkg::PMEEN_BIT];
                if (dataSelWrEn) begin
                    st_next.dataSel = mergedWord[ppc_pkg::DSEL_LSB +: 4];
                end
            end else if (a == ppc_pkg::OFF_MSI_CAP) begin
                st_next.msiEn = mergedWord[ppc_pkg::MSIEN_BIT];
                st_next.msiMme = mergedWord[ppc_pkg::MME_LSB +: 3];
            end else if (a == ppc_pkg::OFF_MSI_ADDR) begin
                st_next.msiAddr = mergedWord[31:ppc_pkg::ADDR_LSB];
            end
        end
        st_next.hotRst = hotRst;
        if (intRst) begin
            // soft reset returns function state to defaults, straps survive
            st_next.intRst = 1'h1;
            st_next.pmeEn = 1'h0;
            st_next.dataSel = 4'h0;
            st_next.msiEn = 1'h0;
            st_next.msiMme = 3'h0;
            st_next.msiAddr = 30'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstSyncB) begin
        if (!rstSyncB) begin
            st_reg <= ST_RST;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign cfgAck         = st_reg.ack;
    assign cfgRdata       = st_reg.rdata;
    assign pwrState       = st_reg.pwrState;
    assign pmeMsgOut      = pmeEventIn && st_reg.pmeEn;
    assign msiEnable      = st_reg.msiEn;
    assign intxPermit     = !st_reg.msiEn;
    assign msiMultiEnable = st_reg.msiMme;
    assign msiAddr        = {st_reg.msiAddr, 2'h0};
    // upper half lives elsewhere; consumers gate it with this flag
    assign msi64Capable   = ppc_pkg::MSI64_CAP;
    assign hotResetPulse  = st_reg.hotRst;
    assign intResetPulse  = st_reg.intRst;
    // the hot reset is kept inside the port, downstream reset stays high
    assign downstream_reset_out_n = 1'h1;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_pm_id;
        take && !cfgIn.wr && cfgIn.addr[7:2] == ppc_pkg::OFF_PM_CAP[7:2]
        |=> cfgAck && cfgRdata[7:0] == 8'h01 && cfgRdata[18:16] == 3'h3;
    endproperty
    a_pm_id: assert property (p_pm_id) else $error("pm id or revision wrong");

    property p_pm_fixed;
        take && !cfgIn.wr && cfgIn.addr[7:2] == ppc_pkg::OFF_PM_CAP[7:2]
        |=> !cfgRdata[19] && !cfgRdata[25] && !cfgRdata[26] && !cfgRdata[20];
    endproperty
    a_pm_fixed: assert property (p_pm_fixed) else $error("pm hardwired bits set");

    property p_pme_st;
        take && !cfgIn.wr && cfgIn.addr[7:2] == ppc_pkg::OFF_PM_CTL[7:2]
        |=> !cfgRdata[15] && cfgRdata[7:4] == 4'h0 && !cfgRdata[2];
    endproperty
    a_pme_st: assert property (p_pme_st) else $error("pme status or reserved set");

    property p_msi_id;
        take && !cfgIn.wr && cfgIn.addr[7:2] == ppc_pkg::OFF_MSI_CAP[7:2]
        |=> cfgRdata[7:0] == 8'h05 && cfgRdata[23] && cfgRdata[31:24] == 8'h00;
    endproperty
    a_msi_id: assert property (p_msi_id) else $error("msi id or capability wrong");

    property p_hot;
        psWrite && st_reg.pwrState == 2'h3 && mergedWord[1:0] == 2'h0
        |=> hotResetPulse ##1 !hotResetPulse || !ce;
    endproperty
    a_hot: assert property (p_hot) else $error("hot reset not pulsed");

    property p_nodrive;
        hotResetPulse |-> downstream_reset_out_n;
    endproperty
    a_nodrive: assert property (p_nodrive) else $error("downstream reset driven");

    property p_pme_gate;
        pmeMsgOut |-> st_reg.pmeEn && pmeEventIn;
    endproperty
    a_pme_gate: assert property (p_pme_gate) else $error("pme sent while disabled");

    property p_dsel;
        ce && !dataSelWrEn && !intRst |=> $stable(st_reg.dataSel);
    endproperty
    a_dsel: assert property (p_dsel) else $error("data select changed while locked");

    property p_addr_lo;
        msiAddr[1:0] == 2'h0 && intxPermit != msiEnable;
    endproperty
    a_addr_lo: assert property (p_addr_lo) else $error("msi address or intx wrong");

    // strap fields checked against the strap copy seen when the read was taken
    property p_pm_next;
        take && !cfgIn.wr && cfgIn.addr[7:2] == ppc_pkg::OFF_PM_CAP[7:2]
        |=> cfgRdata[15:8] == $past(st_reg.strap.pmNext);
    endproperty
    a_pm_next: assert property (p_pm_next) else $error("pm next pointer wrong");

    property p_msi_next;
        take && !cfgIn.wr && cfgIn.addr[7:2] == ppc_pkg::OFF_MSI_CAP[7:2]
        |=> cfgRdata[15:8] == $past(st_reg.strap.msiNext) && cfgRdata[19:17] == 3'h0;
    endproperty
    a_msi_next: assert property (p_msi_next) else $error("msi next pointer wrong");

    property p_pm_rev;
        take && !cfgIn.wr && cfgIn.addr[7:2] == ppc_pkg::OFF_PM_CAP[7:2]
        |=> cfgRdata[18:16] == ppc_pkg::PM_REV && !cfgRdata[19];
    endproperty
    a_pm_rev: assert property (p_pm_rev) else $error("pm revision wrong");

    property p_pme_sup;
        take && !cfgIn.wr && cfgIn.addr[7:2] == ppc_pkg::OFF_PM_CAP[7:2]
        |=> cfgRdata[31:27] == $past(st_reg.strap.pmeSupport);
    endproperty
    a_pme_sup: assert property (p_pme_sup) else $error("pme support field wrong");

    property p_dsi;
        take && !cfgIn.wr && cfgIn.addr[7:2] == ppc_pkg::OFF_PM_CAP[7:2]
        |=> cfgRdata[21] == $past(st_reg.strap.devSpecInit);
    endproperty
    a_dsi: assert property (p_dsi) else $error("device init bit wrong");

    property p_ps_wr;
        psWrite |=> pwrState == $past(cfgIn.wdata[ppc_pkg::PS_LSB +: 2]);
    endproperty
    a_ps_wr: assert property (p_ps_wr) else $error("power state not written");

    property p_nosoft;
        take && !cfgIn.wr && cfgIn.addr[7:2] == ppc_pkg::OFF_PM_CTL[7:2]
        |=> cfgRdata[3] == $past(st_reg.strap.noSoftRst);
    endproperty
    a_nosoft: assert property (p_nosoft) else $error("no soft reset bit wrong");

    property p_soft;
        hotResetPulse |-> intResetPulse == !$past(st_reg.strap.noSoftRst);
    endproperty
    a_soft: assert property (p_soft) else $error("internal reset choice wrong");

    property p_soft_clr;
        intResetPulse |-> !msiEnable && !st_reg.pmeEn && msiAddr == 32'h0;
    endproperty
    a_soft_clr: assert property (p_soft_clr) else $error("internal reset left state");

    property p_msi_en;
        take && cfgIn.wr && cfgIn.be[2] && cfgIn.addr[7:2] == ppc_pkg::OFF_MSI_CAP[7:2]
        |=> msiEnable == $past(cfgIn.wdata[16]) && intxPermit == !msiEnable;
    endproperty
    a_msi_en: assert property (p_msi_en) else $error("msi enable not written");

    property p_addr_wr;
        take && cfgIn.wr && cfgIn.be == 4'hf && cfgIn.addr[7:2] == ppc_pkg::OFF_MSI_ADDR[7:2]
        |=> msiAddr == {$past(cfgIn.wdata[31:2]), 2'h0};
    endproperty
    a_addr_wr: assert property (p_addr_wr) else $error("msi address not written");

    property p_rsvd;
        take && !cfgIn.wr && cfgIn.addr[7:2] != ppc_pkg::OFF_PM_CAP[7:2]
        && cfgIn.addr[7:2] != ppc_pkg::OFF_PM_CTL[7:2]
        && cfgIn.addr[7:2] != ppc_pkg::OFF_MSI_CAP[7:2]
        && cfgIn.addr[7:2] != ppc_pkg::OFF_MSI_ADDR[7:2] |=> cfgRdata == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("unmapped read not zero");

    c_read: cover property (take && !cfgIn.wr ##1 cfgAck);
    c_hot: cover property (hotResetPulse);
    c_intrst: cover property (intResetPulse);
    c_msi: cover property (!msiEnable ##1 msiEnable);
endmodule
`default_nettype wire

/* File: testbench/ppc_cfg_requester.sv */
// Purpose: upstream configuration requester driving the capability block
// Assumes: request taken at the edge after it is raised, answer one cycle later
// Notes:   released fields are inverted so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module ppc_cfg_requester (
    // clock
    input  wire logic                  clk_sys,
    // request side
    output var logic                   cfgReq,
    output var ppc_pkg::ppc_cfg_req_t  cfgIn,
    // answer side
    input  wire logic                  cfgAck,
    input  wire logic [31:0]           cfgRdata
);
    int nLost = 0;

    initial begin
        cfgReq = 1'b0;
        cfgIn  = '0;
    end

    // ----------------------------------------
    // one access, bounded wait for the answer
    // ----------------------------------------
    task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                          input logic [31:0] wdata, output logic [31:0] rdata);
        int n;
        @(posedge clk_sys);
        #1;
        cfgReq = 1'b1;
        cfgIn  = '{wr: wr, addr: addr, be: be, wdata: wdata};
        @(posedge clk_sys);
        // taken at this edge; holding longer would issue a second request
        #1;
        cfgReq = 1'b0;
        cfgIn  = ~cfgIn;
        rdata  = 'x;
        for (n = 0; n < 8; n++) begin
            @(posedge clk_sys);
            if (cfgAck === 1'b1) begin
                rdata = cfgRdata;
                break;
            end
        end
        if (n == 8) begin
            nLost++;
        end
        #1;
    endtask
endmodule
`default_nettype wire

/* File: testbench/test_pcie_port_pm_msi_capability.sv */
// Purpose: register-level test of the PM and MSI capability block
// Assumes: straps at package defaults until a load is pulsed
// Notes:   reset pulses are counted on every edge, not sampled once
`timescale 1ns/1ps
`default_nettype none
module test_pcie_port_pm_msi_capability;
    logic                  clk_sys     = 1'b0;
    logic                  rst_b       = 1'b0;
    logic                  strapLoad   = 1'b0;
    ppc_pkg::ppc_strap_t   strapIn     = ppc_pkg::STRAP_DEF;
    logic                  dataSelWrEn = 1'b0;
    logic                  ce          = 1'b1;
    logic                  pmeEventIn  = 1'b0;
    logic                  cfgReq;
    ppc_pkg::ppc_cfg_req_t cfgIn;
    logic                  cfgAck;
    logic [31:0]           cfgRdata;
    logic                  pmeMsgOut;
    logic                  msiEnable;
    logic                  intxPermit;
    logic [2:0]            msiMultiEnable;
    logic [31:0]           msiAddr;
    logic                  msi64Capable;
    logic [1:0]            pwrState;
    logic                  hotResetPulse;
    logic                  intResetPulse;
    logic                  dsResetN;
    int                    nMismatch = 0;
    int                    nTests    = 0;
    int                    nHot      = 0;
    int                    nInt      = 0;
    int                    nDsLow    = 0;

    always #25 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (hotResetPulse === 1'b1) nHot++;
        if (intResetPulse === 1'b1) nInt++;
        if (dsResetN !== 1'b1 && rst_b === 1'b1) nDsLow++;
    end

    ppc_cap_regs ppc_cap_regs_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .cfgReq(cfgReq), .cfgIn(cfgIn),
        .cfgAck(cfgAck), .cfgRdata(cfgRdata), .strapLoad(strapLoad), .strapIn(strapIn),
        .dataSelWrEn(dataSelWrEn), .pmeEventIn(pmeEventIn), .pmeMsgOut(pmeMsgOut),
        .msiEnable(msiEnable), .intxPermit(intxPermit), .msiMultiEnable(msiMultiEnable),
        .msiAddr(msiAddr), .msi64Capable(msi64Capable), .pwrState(pwrState),
        .hotResetPulse(hotResetPulse), .intResetPulse(intResetPulse),
        .downstream_reset_out_n(dsResetN));

    ppc_cfg_requester ppc_cfg_requester_inst (
        .clk_sys(clk_sys), .cfgReq(cfgReq), .cfgIn(cfgIn), .cfgAck(cfgAck),
        .cfgRdata(cfgRdata));

    // ----------------------------------------
    // compare, access and closing tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            nMismatch++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrReg(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] unused;
        ppc_cfg_requester_inst.access(1'b1, addr, be, d, unused);
    endtask

    task automatic rdCheck(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] got;
        ppc_cfg_requester_inst.access(1'b0, addr, 4'hf, 32'h0000_0000, got);
        check(got, exp);
    endtask

    task automatic tally_and_finish();
        if (nMismatch == 0 && nTests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #100_000;
        nMismatch++;
        tally_and_finish();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk_sys);
        rdCheck(8'h40, 32'hc803_4801);
        rdCheck(8'h44, 32'h0000_0008);
        rdCheck(8'h48, 32'h0080_6805);
        rdCheck(8'h4c, 32'h0000_0000);
        rdCheck(8'h60, 32'h0000_0000);
        check({31'h0, msi64Capable}, 32'h1);
        check({31'h0, intxPermit}, 32'h1);
        pmeEventIn = 1'b1;
        #1 check({31'h0, pmeMsgOut}, 32'h0);
        // the read-only PM capability word at 40h must shrug off an all-ones write
        wrReg(8'h40, 4'hf, 32'hffff_ffff);
        rdCheck(8'h40, 32'hc803_4801);
        // data select locked while the external enable is low
        wrReg(8'h44, 4'hf, 32'hffff_ffff);
        rdCheck(8'h44, 32'h0000_010b);
        check({31'h0, pmeMsgOut}, 32'h1);
        dataSelWrEn = 1'b1;
        wrReg(8'h44, 4'h2, 32'hffff_ffff);
        rdCheck(8'h44, 32'h0000_1f0b);
        // D3hot to D0 with the no-soft-reset strap set
        wrReg(8'h44, 4'h1, 32'h0000_0000);
        check({30'h0, pwrState}, 32'h0);
        check(nHot, 32'h1);
        check(nInt, 32'h0);
        rdCheck(8'h44, 32'h0000_1f08);
        for (int i = 0; i < 4; i++) begin
            wrReg(8'h44, 4'h1, 32'(i));
            check({30'h0, pwrState}, 32'(i));
        end
        check(nHot, 32'h1);
        // MSI enable, message count and aligned address
        wrReg(8'h48, 4'hf, 32'hffff_ffff);
        rdCheck(8'h48, 32'h00f1_6805);
        check({31'h0, msiEnable}, 32'h1);
        check({31'h0, intxPermit}, 32'h0);
        check({29'h0, msiMultiEnable}, 32'h7);
        wrReg(8'h4c, 4'hf, 32'hffff_ffff);
        rdCheck(8'h4c, 32'hffff_fffc);
        check(msiAddr, 32'hffff_fffc);
        // enable low: the request is never taken, the address must survive
        ce = 1'b0;
        wrReg(8'h4c, 4'hf, 32'h0000_0000);
        ce = 1'b1;
        rdCheck(8'h4c, 32'hffff_fffc);
        // new straps: other pointers, data byte, soft reset allowed
        strapIn = '{pmNext: 8'h5a, msiNext: 8'h77, noSoftRst: 1'h0, devSpecInit: 1'h0,
                    auxCurrent: 3'h0, pmeSupport: ppc_pkg::PME_SUP_DEF, dataByte: 8'ha5};
        @(posedge clk_sys);
        #1 strapLoad = 1'b1;
        @(posedge clk_sys);
        #1 strapLoad = 1'b0;
        rdCheck(8'h40, 32'hc803_5a01);
        wrReg(8'h44, 4'h1, 32'h0000_0000);
        check(nHot, 32'h2);
        check(nInt, 32'h1);
        rdCheck(8'h44, 32'ha500_0000);
        rdCheck(8'h48, 32'h0080_7705);
        check({31'h0, intxPermit}, 32'h1);
        check({31'h0, pmeMsgOut}, 32'h0);
        check(nDsLow, 32'h0);
        check(ppc_cfg_requester_inst.nLost, 32'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
